// ==== hdl/host_bus_sram_decoder.sv ====
/*
  bytewide host port decoder: steers host reads either to the sixteen clock registers
  at the top of the map or to an external sram, lets writes in that window reach both,
  drives the sram chip select and output strobe, and write protects both
  while supply is out of tolerance and for a while after it returns.
  assumes host pins and the power-fail comparator are asynchronous to clk;
  the host write strobe and data go straight to the sram on the board.
*/
// Contract
// - accept a 19-bit byte address, reaching up to 512k external bytes
// - clock registers always sit at the top of the map
// - ram output strobe stays inactive while a clock register is addressed
// - one continuous map; physical ram placement hidden from host
// - read when chip enable low, write enable high; drive only with oe low
// - reads in the top sixteen bytes return the clock register
// - reads outside the window pass host oe to ram output strobe
// - read data valid only after address stable and both enables low
// - write mode when chip enable and write enable both low; oe ignored
// - write begins at the later falling edge of ce or we
// - write ends at the earlier rising edge; byte captured there
// - data outputs release once write enable goes low
// - writes to 7fff0h-7ffffh store into the clock register
// - writes outside the window go to the ram, not to registers
// - in power fail the host strobes are ignored, no writes happen
// - while supply is out of tolerance ram chip select is forced high
// - after supply returns, protection and reset output hold 200 ms
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.svh"

module host_bus_sram_decoder
  import host_port_pkg::*;
#(
  parameter int ADDR_W      = `HBD_ADDR_W,
  parameter int DATA_W      = `HBD_DATA_W,
  parameter int RECOVER_CYC = `HBD_PF_RECOVER_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [ADDR_W-1:0]    host_addr,
  input  wire host_strobes_t        host_strobes,
  input  wire logic [DATA_W-1:0]    data_in,
  output logic      [DATA_W-1:0]    data_out,
  output logic                      data_oe_n,
  input  wire logic                 power_fail_threshold,
  output ram_ctrl_t                 ram_ctrl,
  output logic                      reset_pin_out,
  output logic                      reset_pin_oe_n
);

  localparam int IDX_W = `HBD_CLKREG_IDX_W;
  localparam int CNT_W = $clog2(RECOVER_CYC + 1);
  localparam logic [CNT_W-1:0] RECOVER_LOAD = CNT_W'(RECOVER_CYC);

  // refuse shapes the decoder cannot serve
  // recovery hold shorter than eight cycles would break the hold check
  if (ADDR_W != `HBD_ADDR_W || DATA_W != `HBD_DATA_W || RECOVER_CYC < 8) begin : g_bad_param
    $error("host_bus_sram_decoder: unsupported parameter values");
  end

  // address falls in the clock register window
  function automatic logic is_clock_reg(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:IDX_W] == (ADDR_W-IDX_W)'(`HBD_CLKREG_BASE >> IDX_W);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: two flops on every pin before any logic

  logic [ADDR_W-1:0] addr_m_q,  addr_s_q;
  logic [DATA_W-1:0] din_m_q,   din_s_q;
  host_strobes_t     stb_m_q,   stb_s_q;
  logic              pf_m_q,    pf_s_q;

  // strobes reset to deselected so nothing fires on release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_m_q <= `HBD_ADDR_RST;
      addr_s_q <= `HBD_ADDR_RST;
      din_m_q  <= `HBD_DATA_RST;
      din_s_q  <= `HBD_DATA_RST;
      stb_m_q  <= '1;
      stb_s_q  <= '1;
      pf_m_q   <= 1'b1;
      pf_s_q   <= 1'b1;
    end else begin
      addr_m_q <= host_addr;
      addr_s_q <= addr_m_q;
      din_m_q  <= data_in;
      din_s_q  <= din_m_q;
      stb_m_q  <= host_strobes;
      stb_s_q  <= stb_m_q;
      pf_m_q   <= power_fail_threshold;
      pf_s_q   <= pf_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-fail protection and recovery hold

  logic [CNT_W-1:0] recover_cnt_q, recover_cnt_d;
  logic             protect;

  always_comb begin
    if (pf_s_q) begin
      recover_cnt_d = RECOVER_LOAD;
    end else if (recover_cnt_q != '0) begin
      recover_cnt_d = recover_cnt_q - CNT_W'(1);
    end else begin
      recover_cnt_d = recover_cnt_q;
    end
  end

  // starts loaded so power-up behaves like a recovery
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recover_cnt_q <= RECOVER_LOAD;
    end else begin
      recover_cnt_q <= recover_cnt_d;
    end
  end

  assign protect = pf_s_q || (recover_cnt_q != '0);

  ////////////////////////////////////////////////////////////////////////////
  // decode of the current host cycle

  logic clk_hit;
  logic sel;
  logic rd_drive;

  assign clk_hit  = is_clock_reg(addr_s_q);
  assign sel      = !stb_s_q.ce_n && !protect;
  assign rd_drive = sel && stb_s_q.we_n && !stb_s_q.oe_n && clk_hit;

  ////////////////////////////////////////////////////////////////////////////
  // write cycle tracking

  wr_state_t         wr_state_q,  wr_state_d;
  logic [IDX_W-1:0]  wr_idx_q,    wr_idx_d;
  logic              wr_hit_q,    wr_hit_d;
  logic [DATA_W-1:0] wr_byte_q,   wr_byte_d;
  logic              commit;

  always_comb begin
    wr_state_d = wr_state_q;
    wr_idx_d   = wr_idx_q;
    wr_hit_d   = wr_hit_q;
    wr_byte_d  = wr_byte_q;
    commit     = 1'b0;
    unique case (wr_state_q)
      WR_IDLE: begin
        if (sel && !stb_s_q.we_n) begin
          wr_state_d = WR_ACTIVE;
          wr_idx_d   = addr_s_q[IDX_W-1:0];
          wr_hit_d   = clk_hit;
          wr_byte_d  = din_s_q;
        end
      end
      WR_ACTIVE: begin
        if (protect) begin
          wr_state_d = WR_IDLE;
        end else if (stb_s_q.ce_n || stb_s_q.we_n) begin
          // idle again once a strobe is high, as under protect above
          wr_state_d = WR_IDLE;
          commit     = wr_hit_q;
        end else begin
          // last byte seen while both strobes were low
          wr_byte_d  = din_s_q;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_state_q <= WR_IDLE;
      wr_idx_q   <= '0;
      wr_hit_q   <= 1'b0;
      wr_byte_q  <= `HBD_DATA_RST;
    end else begin
      wr_state_q <= wr_state_d;
      wr_idx_q   <= wr_idx_d;
      wr_hit_q   <= wr_hit_d;
      wr_byte_q  <= wr_byte_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock register store

  logic [DATA_W-1:0] rd_data;

  // low index bits pick the register
  clock_reg_file #(
    .WIDTH (DATA_W),
    .IDX_W (IDX_W)
  ) u_regs (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (commit),
    .wr_idx    (wr_idx_q),
    .wr_data   (wr_byte_q),
    .rd_idx    (addr_s_q[IDX_W-1:0]),
    .rd_data_q (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  logic              drive_pre_q, drive_pre_d;
  logic              data_oe_n_d;
  ram_ctrl_t         ram_ctrl_d;

  always_comb begin
    drive_pre_d = rd_drive;
    // drive only once read data has caught up
    data_oe_n_d = !(rd_drive && drive_pre_q);
    ram_ctrl_d.chip_select_n   = protect ? 1'b1 : stb_s_q.ce_n;
    ram_ctrl_d.output_strobe_n = (protect || clk_hit) ? 1'b1 : stb_s_q.oe_n;
  end

  // data path costs a few cycles of latency; release takes one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_pre_q    <= 1'b0;
      data_oe_n      <= 1'b1;
      data_out       <= `HBD_DATA_RST;
      ram_ctrl       <= '1;
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= 1'b0;
    end else begin
      drive_pre_q    <= drive_pre_d;
      data_oe_n      <= data_oe_n_d;
      data_out       <= rd_data;
      ram_ctrl       <= ram_ctrl_d;
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= !protect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_low;
    wr_state_q == WR_ACTIVE && !protect && !stb_s_q.ce_n && !stb_s_q.we_n;
  endsequence

  sequence s_wr_rise;
    wr_state_q == WR_ACTIVE && !protect && (stb_s_q.ce_n || stb_s_q.we_n);
  endsequence

  AST_OE_HELD_IN_WINDOW: assert property (
    clk_hit |=> ram_ctrl.output_strobe_n)
    else $error("ram output strobe active on clock register access");

  AST_OE_PASS_THROUGH: assert property (
    (!clk_hit && !protect) |=> ram_ctrl.output_strobe_n == $past(stb_s_q.oe_n))
    else $error("ram output strobe does not follow host oe");

  AST_CS_FOLLOWS_CE: assert property (
    !protect |=> ram_ctrl.chip_select_n == $past(stb_s_q.ce_n))
    else $error("ram chip select does not follow host ce");

  AST_CS_BLOCKED: assert property (
    protect |=> ram_ctrl.chip_select_n && !reset_pin_oe_n)
    else $error("ram selected or reset released while protected");

  AST_DRIVE_ONLY_READ: assert property (
    !data_oe_n |-> $past(rd_drive, 1) && $past(rd_drive, 2))
    else $error("data bus driven without a settled register read");

  AST_WE_RELEASES: assert property (
    !stb_s_q.we_n |=> data_oe_n)
    else $error("data bus still driven during write");

  AST_COMMIT_BYTE: assert property (
    s_wr_low ##1 (s_wr_rise and wr_hit_q) |-> commit && wr_byte_q == $past(din_s_q))
    else $error("write end did not store the last byte");

  AST_NO_COMMIT_OUTSIDE: assert property (
    commit |-> wr_hit_q && !protect)
    else $error("register written outside window or while protected");

  AST_RECOVER_HOLD: assert property (
    $fell(pf_s_q) |-> protect [*8])
    else $error("protection dropped too soon after recovery");

endmodule

`default_nettype wire

// ==== shared/host_port_defs.svh ====
/*
  constants of the bytewide host port: address layout, clock register window,
  timing figures and reset values.
  assumes a single 40 mhz system clock; included by bare name, defines only.
*/
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// host address and data widths
`define HBD_ADDR_W         19
`define HBD_DATA_W         8
// clock registers: top sixteen bytes of the map
`define HBD_CLKREG_IDX_W   4
`define HBD_CLKREG_BASE    19'h7fff0
`define HBD_CLKREG_TOP     19'h7ffff
// system clock rate and power-up write protection time
`define HBD_CLK_MHZ        40
`define HBD_PF_RECOVER_MS  200
`define HBD_PF_RECOVER_CYC (`HBD_PF_RECOVER_MS * `HBD_CLK_MHZ * 1000)
// reset values
`define HBD_DATA_RST       8'h00
`define HBD_ADDR_RST       19'h00000

`endif

// ==== shared/host_port_pkg.sv ====
/*
  types shared by the host port decoder, the sram model and the bench.
  assumes host_port_defs.svh for widths.
*/
`default_nettype none
`include "host_port_defs.svh"

package host_port_pkg;

  // host strobes, all active low
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } host_strobes_t;

  // external ram control outputs, active low
  typedef struct packed {
    logic chip_select_n;
    logic output_strobe_n;
  } ram_ctrl_t;

  // write cycle tracker
  typedef enum logic [0:0] {
    WR_IDLE,
    WR_ACTIVE
  } wr_state_t;

endpackage

`default_nettype wire

// ==== hdl/clock_reg_file.sv ====
/*
  small store for the on-chip clock registers, one write port and one read
  port whose data leave through a register.
  assumes write address, data and enable come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module clock_reg_file #(
  parameter int WIDTH = 8,
  parameter int IDX_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [WIDTH-1:0] rd_data_q
);

  // refuse shapes the store cannot hold
  if (WIDTH < 1 || IDX_W < 1) begin : g_bad_param
    $error("clock_reg_file: unsupported parameter values");
  end

  logic [WIDTH-1:0] mem [2**IDX_W];

  // contents are not reset; backed storage keeps its value
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem[rd_idx];
    end
  end

endmodule

`default_nettype wire

// ==== testbench/sram_model.sv ====
/*
  behavioural static ram on the far side of the decoder.
  assumes the decoder's ram controls and the board's direct write strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module sram_model
  import host_port_pkg::*;
(
  input  wire logic       clk,
  input  wire ram_ctrl_t  ctrl,
  input  wire logic [7:0] addr,
  input  wire logic       we_n,
  input  wire logic [7:0] dq_in,
  output logic      [7:0] dq_out
);
  logic [7:0] mem [256];
  logic [7:0] idle_q = 8'h00;
  logic       drive;

  ////////////////////////////////////////////////////////////
  // cells take the byte at the end of a selected write
  always @(posedge we_n) begin
    if (ctrl.chip_select_n == 1'b0) begin
      mem[addr] <= dq_in;
    end
  end

  // drives only while selected, strobed and not writing
  assign drive = !ctrl.chip_select_n && !ctrl.output_strobe_n && we_n;

  // released bus toggles so a stale byte never passes for data
  always @(posedge clk) begin
    idle_q <= ~dq_out;
  end
  assign dq_out = drive ? mem[addr] : idle_q;
endmodule

`default_nettype wire

// ==== testbench/host_bus_sram_decoder_tb.sv ====
/*
  bench for host_bus_sram_decoder with a reference model in integers.
  assumes sram_model on the ram side; 40 mhz clock, short recovery count.
*/
`timescale 1ns/1ps
`default_nettype none

module host_bus_sram_decoder_tb;
  import host_port_pkg::*;
  localparam int REC = 16;
  logic          clk, rst, pf, host_drive, prot;
  logic [18:0]   host_addr;
  host_strobes_t host_strobes;
  logic [7:0]    host_dq, data_out, ram_q, bus;
  logic          data_oe_n, reset_pin_out, reset_pin_oe_n;
  ram_ctrl_t     ram_ctrl;
  int            failures, samples_checked, seed, n;
  int            regs[16];
  int            ram_mem[256];
  logic [18:0]   ra[8];

  // shared data bus; host wins so contention never hides a write
  assign bus = host_drive ? host_dq : (data_oe_n === 1'b0) ? data_out : ram_q;

  host_bus_sram_decoder #(.RECOVER_CYC(REC)) u_host_bus_sram_decoder (
    .clk(clk), .rst(rst), .host_addr(host_addr), .host_strobes(host_strobes),
    .data_in(bus), .data_out(data_out), .data_oe_n(data_oe_n),
    .power_fail_threshold(pf), .ram_ctrl(ram_ctrl),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));

  sram_model u_sram_model (.clk(clk), .ctrl(ram_ctrl), .addr(host_addr[7:0]),
    .we_n(host_strobes.we_n), .dq_in(bus), .dq_out(ram_q));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // cycles until the reset pin lets go, bounded
  task automatic wait_free(output int c);
    c = 0;
    while (reset_pin_oe_n !== 1'b1 && c < 200) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // one host cycle; strobes low 6 clocks, then high 5 clocks
  task automatic acc(input logic [18:0] a, input logic wr, input logic oe, input logic [7:0] d);
    logic win;
    win = (a >= 19'h7fff0);
    @(posedge clk);
    host_addr <= a;
    host_strobes <= {1'b0, oe, !wr};
    host_dq <= d;
    host_drive <= wr;
    tick(5);
    #1;
    chk(ram_ctrl, prot ? 2'b11 : {1'b0, win | oe});
    if (!wr) chk(data_oe_n, prot || !(win && !oe));
    if (!wr && !prot && !oe) chk(win ? data_out : bus, win ? regs[a[3:0]] : ram_mem[a[7:0]]);
    @(posedge clk);
    host_strobes <= 3'b111;
    if (wr && !prot) begin
      ram_mem[a[7:0]] = d;
      if (win) regs[a[3:0]] = d;
    end
    tick(4);
    host_drive <= 1'b0;
    #1;
    chk(data_oe_n, 1'b1);
    chk(ram_ctrl, 2'b11);
  endtask

  ////////////////////////////////////////////////////////////
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard
  initial begin
    #(25 * 8000);
    failures++;
    wrap_up();
  end

  // main sequence
  initial begin
    seed = 32'h4e9ea088;
    rst = 1'b1;
    pf = 1'b0;
    host_addr = 19'h00000;
    host_strobes = 3'b111;
    host_dq = 8'h00;
    host_drive = 1'b0;
    prot = 1'b1;
    tick(16);
    #1;
    chk(ram_ctrl, 2'b11);
    chk(reset_pin_oe_n, 1'b0);
    chk(reset_pin_out, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    wait_free(n);
    chk(n >= REC && n <= REC + 8, 1'b1);
    prot = 1'b0;
    // odd indices write with oe high, even with oe low
    for (int i = 0; i < 16; i++) acc(19'h7fff0 + 19'(i), 1'b1, i[0], 8'($random(seed)));
    for (int i = 0; i < 16; i++) acc(19'h7fff0 + 19'(i), 1'b0, 1'b0, 8'h00);
    acc(19'h7fff2, 1'b0, 1'b1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ra[i] = {3'b000, 8'($random(seed)), 8'(i)};
      acc(ra[i], 1'b1, 1'b1, 8'($random(seed)));
    end
    for (int i = 0; i < 8; i++) begin
      acc(ra[i], 1'b0, 1'b0, 8'h00);
      acc(ra[i], 1'b0, 1'b1, 8'h00);
    end
    acc(19'h7ffe3, 1'b1, 1'b1, 8'hc3);
    acc(19'h7fff3, 1'b0, 1'b0, 8'h00);
    acc(19'h7ffe3, 1'b0, 1'b0, 8'h00);
    // read a register, then lower write enable mid-read
    @(posedge clk);
    host_addr <= 19'h7fff5;
    host_strobes <= 3'b001;
    tick(5);
    #1;
    chk(data_oe_n, 1'b0);
    @(posedge clk);
    host_dq <= 8'h5a;
    host_drive <= 1'b1;
    host_strobes <= 3'b000;
    tick(4);
    #1;
    chk(data_oe_n, 1'b1);
    @(posedge clk);
    host_strobes <= 3'b111;
    regs[5] = 8'h5a;
    ram_mem[8'hf5] = 8'h5a;
    tick(4);
    host_drive <= 1'b0;
    acc(19'h7fff5, 1'b0, 1'b0, 8'h00);
    // supply fails in the middle of a register write; the write is lost
    @(posedge clk);
    host_addr <= 19'h7fff1;
    host_strobes <= 3'b010;
    host_dq <= 8'(~regs[1]);
    host_drive <= 1'b1;
    tick(3);
    pf <= 1'b1;
    tick(4);
    prot = 1'b1;
    #1;
    chk(ram_ctrl.chip_select_n, 1'b1);
    chk(reset_pin_oe_n, 1'b0);
    chk(reset_pin_out, 1'b0);
    @(posedge clk);
    host_strobes <= 3'b111;
    tick(4);
    host_drive <= 1'b0;
    acc(19'h7fff0, 1'b1, 1'b1, 8'(~regs[0]));
    acc(ra[0], 1'b1, 1'b1, 8'h3c);
    acc(19'h7fff0, 1'b0, 1'b0, 8'h00);
    @(posedge clk);
    pf <= 1'b0;
    wait_free(n);
    chk(n >= REC && n <= REC + 8, 1'b1);
    prot = 1'b0;
    acc(19'h7fff0, 1'b0, 1'b0, 8'h00);
    acc(19'h7fff1, 1'b0, 1'b0, 8'h00);
    acc(ra[0], 1'b0, 1'b0, 8'h00);
    // reset again mid-run; register contents survive it
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    #1;
    chk(ram_ctrl, 2'b11);
    chk(data_oe_n, 1'b1);
    chk(reset_pin_oe_n, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    wait_free(n);
    chk(n >= REC && n <= REC + 8, 1'b1);
    acc(19'h7fff5, 1'b0, 1'b0, 8'h00);
    wrap_up();
  end
endmodule

`default_nettype wire
